// *** logic/cgsf_top.sv ***
// Function
// (RL1) Overload bit high while own overload sends
// (RL2) Tx-active bit high while any frame emitted
// (RL3) Tx-active also during spacing with pending frame
// (RL4) Rx-active bit high while receiving or monitoring
// (RL5) Enabled bit shows real state, lags command
// (RL6) Machine starts two clocks after enable command; machine_run rises four clocks after it here
// (RL7) Standby: transmit recessive, receiver held off
// (RL8) Four activity status bits never raise interrupts
// (RL9) Status register read-only, writes ignored
// (RL10) Reserved status bits undefined; never write ones
// (RL11) Summary bit equals OR of interrupt requests
// (RL12) Timer wrap from max to zero sets flag
// (RL13) Enabled timer flag interrupts until software clears
// (RL14) Buffer full sets overrun flag until cleared
// (RL15) CRC over destuffed frame, mismatch sets flag
// (RL16) Fixed-form field violation sets form flag
// (RL17) CRC and form flags interrupt, software clears
// (RL18) Six equal stuffed bits set stuff flag
// (RL19) Missing dominant ack sets ack flag
`timescale 1ns/1ps
module cgsf_top
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic [7:0]            sfr_addr,
	input  wire logic                  sfr_wr,
	input  wire logic                  sfr_rd,
	input  wire logic [7:0]            sfr_wdata,
	output logic      [7:0]            sfr_rdata,
	input  wire logic                  enable_standby_control,
	input  wire cgsf_pkg::cgsf_engine_s engine,
	input  wire logic                  engine_tx_level,
	input  wire cgsf_pkg::cgsf_rxbit_s rx_bit,
	input  wire logic [15:0]           can_timer,
	input  wire logic                  rx_buffer_full,
	input  wire logic                  timer_irq_enable,
	input  wire logic                  gen_err_irq_enable,
	input  wire logic                  buf_irq_enable,
	input  wire logic                  other_irq_req,
	output logic                       can_tx,
	output logic                       rx_enable,
	output logic                       machine_run,
	output logic                       can_irq,
	output logic      [7:0]            general_status,
	output logic      [7:0]            general_interrupt_flags
);
	import cgsf_pkg::*;

	logic                   rst_meta_q;
	logic                   rst_n;
	cgsf_ctl_e              ctl_q;
	logic [1:0]             start_cnt_q;
	logic                   running;
	logic                   frame_busy;
	logic [7:0]             gsta_q;
	logic [CGSF_NFLAGS-1:0] flag_set;
	logic [CGSF_NFLAGS-1:0] flag_clr;
	logic [CGSF_NFLAGS-1:0] flags_q;
	logic [15:0]            timer_prev_q;
	logic                   buf_full_q;
	logic                   last_level_q;
	logic [2:0]             run_q;
	logic                   same_level;
	logic                   stuff_err;
	logic [14:0]            crc_q;
	logic                   irq_d;
	logic                   irq_q;
	logic                   git_wr;

	// Reset synchroniser; only the second stage is used downstream
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// A frame in flight must finish before standby is entered
	assign frame_busy = engine.frame_tx | engine.ack_tx | engine.ovl_tx |
		engine.rx_busy;

	// Enable/standby sequencing
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_q       <= CGSF_STANDBY;
			start_cnt_q <= '0;
		end
		else
		begin
			unique case (ctl_q)
				CGSF_STANDBY:
				begin
					start_cnt_q <= '0;
					if (enable_standby_control)
						ctl_q <= CGSF_STARTING;
				end
				CGSF_STARTING:
				begin
					start_cnt_q <= start_cnt_q + 2'h1;
					if (!enable_standby_control)
						ctl_q <= CGSF_STANDBY;
					else if (start_cnt_q == CGSF_START_LAST)
						ctl_q <= CGSF_RUNNING; // RL6
				end
				CGSF_RUNNING:
				begin
					if (!enable_standby_control)
						ctl_q <= CGSF_STOPPING;
				end
				CGSF_STOPPING:
				begin
					if (enable_standby_control)
						ctl_q <= CGSF_RUNNING;
					else if (!frame_busy)
						ctl_q <= CGSF_STANDBY;
				end
			endcase
		end
	end

	assign running = (ctl_q == CGSF_RUNNING) || (ctl_q == CGSF_STOPPING);

	// Pin side: recessive and receiver off whenever stopped
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			can_tx      <= CGSF_RECESSIVE;
			rx_enable   <= 1'b0;
			machine_run <= 1'b0;
		end
		else
		begin
			can_tx      <= running ? engine_tx_level : CGSF_RECESSIVE; // RL7
			rx_enable   <= running; // RL7
			machine_run <= running;
		end
	end

	// Status image, refreshed every cycle; reserved bits read zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			gsta_q <= CGSF_GSTA_RST;
		else
		begin
			gsta_q <= '0; // RL10
			gsta_q[CGSF_GSTA_OVL] <= running & engine.ovl_tx; // RL1
			gsta_q[CGSF_GSTA_TX]  <= running & (engine.frame_tx |
				engine.ovl_tx | engine.ack_tx | // RL2
				(engine.ifs & engine.tx_pending)); // RL3
			gsta_q[CGSF_GSTA_RX]   <= running & engine.rx_busy; // RL4
			gsta_q[CGSF_GSTA_EN]   <= running; // RL5
			gsta_q[CGSF_GSTA_BUS_OFF_STATE] <= engine.bus_off;
			gsta_q[CGSF_GSTA_ERROR_PASSIVE_STATE] <= engine.err_passive;
		end
	end

	// Timer wrap and buffer-full edge detectors
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer_prev_q <= CGSF_TIMER_ZERO;
			buf_full_q   <= 1'b0;
		end
		else
		begin
			timer_prev_q <= can_timer;
			buf_full_q   <= rx_buffer_full;
		end
	end

	// Run-length tracking of stuffed-region bus bits
	assign same_level = (rx_bit.level == last_level_q) && !rx_bit.sof;
	assign stuff_err  = rx_bit.valid && rx_bit.stuff_zone && same_level &&
		(run_q == CGSF_STUFF_MAX);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_level_q <= CGSF_RECESSIVE;
			run_q        <= '0;
		end
		else if (rx_bit.valid)
		begin
			last_level_q <= rx_bit.level;
			// Bits outside the stuffed region never start a run
			// Saturate so a long recessive idle cannot wrap the count
			if (!rx_bit.stuff_zone)
				run_q <= '0;
			else if (!same_level)
				run_q <= CGSF_RUN_ONE;
			else if (run_q != CGSF_STUFF_MAX)
				run_q <= run_q + 3'h1;
		end
	end

	// Receive CRC, started on start of frame
	cgsf_crc15 u_crc
	(
		.clk    (ref_clk),
		.rst_n  (rst_n),
		.init   (rx_bit.valid & rx_bit.sof),
		.shift  (rx_bit.valid & rx_bit.crc_zone), // RL15
		.bit_in (rx_bit.level),
		.crc_q  (crc_q)
	);

	// Hardware set terms for the sticky flags
	always_comb
	begin
		flag_set = '0;
		flag_set[CGSF_GIT_TIM] = (timer_prev_q == CGSF_TIMER_MAX) &&
			(can_timer == CGSF_TIMER_ZERO); // RL12
		flag_set[CGSF_GIT_BUF]  = rx_buffer_full & ~buf_full_q; // RL14
		flag_set[CGSF_GIT_SERR] = stuff_err; // RL18
		flag_set[CGSF_GIT_CERR] = rx_bit.crc_check &&
			(crc_q != CGSF_CRC_INIT); // RL15
		flag_set[CGSF_GIT_FERR] = rx_bit.valid && rx_bit.form_zone &&
			(rx_bit.level == CGSF_DOMINANT); // RL16
		flag_set[CGSF_GIT_AERR] = rx_bit.valid && rx_bit.ack_slot &&
			rx_bit.is_tx && (rx_bit.level == CGSF_RECESSIVE); // RL19
	end

	// Software clears a flag by writing zero to it; status is never hit
	assign git_wr   = sfr_wr && (sfr_addr == CGSF_GIT_ADDR); // RL9
	assign flag_clr = git_wr ? ~sfr_wdata[CGSF_NFLAGS-1:0] : '0; // RL13 RL17

	cgsf_sticky #(.W(CGSF_NFLAGS)) u_flags
	(
		.clk   (ref_clk),
		.rst_n (rst_n),
		.set   (flag_set),
		.clr   (flag_clr),
		.q     (flags_q)
	);

	// Request sources; activity status bits are left out on purpose
	always_comb
	begin
		irq_d = (flags_q[CGSF_GIT_TIM] & timer_irq_enable) | // RL13 RL8
			(flags_q[CGSF_GIT_BUF] & buf_irq_enable) |
			((flags_q[CGSF_GIT_SERR] | flags_q[CGSF_GIT_CERR] |
			flags_q[CGSF_GIT_FERR] | flags_q[CGSF_GIT_AERR]) &
			gen_err_irq_enable) | // RL17
			other_irq_req;
	end

	// Summary bit and interrupt pin come from the same flop
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d; // RL11
	end

	assign can_irq        = irq_q;
	assign general_status = gsta_q;

	always_comb
	begin
		general_interrupt_flags = CGSF_GIT_RST;
		general_interrupt_flags[CGSF_GIT_SUM] = irq_q; // RL11
		general_interrupt_flags[CGSF_NFLAGS-1:0] = flags_q;
	end

	// Registered read port; unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			sfr_rdata <= CGSF_RDATA_NONE;
		else if (sfr_rd)
		begin
			if (sfr_addr == CGSF_GIT_ADDR)
				sfr_rdata <= general_interrupt_flags;
			else if (sfr_addr == CGSF_GSTA_ADDR)
				sfr_rdata <= gsta_q;
			else
				sfr_rdata <= CGSF_RDATA_NONE;
		end
	end
endmodule

// *** logic/cgsf_pkg.sv ***
package cgsf_pkg;
	// Special function register addresses
	localparam logic [7:0]  CGSF_GIT_ADDR   = 8'h9B;
	localparam logic [7:0]  CGSF_GSTA_ADDR  = 8'hAA;
	localparam logic [7:0]  CGSF_GIT_RST    = 8'h00;
	localparam logic [7:0]  CGSF_GSTA_RST   = 8'h00;
	localparam logic [7:0]  CGSF_RDATA_NONE = 8'h00;

	// Status register bit positions
	localparam int CGSF_GSTA_OVL  = 6;
	localparam int CGSF_GSTA_TX   = 4;
	localparam int CGSF_GSTA_RX   = 3;
	localparam int CGSF_GSTA_EN   = 2;
	localparam int CGSF_GSTA_BUS_OFF_STATE = 1;
	localparam int CGSF_GSTA_ERROR_PASSIVE_STATE = 0;

	// Interrupt flag register bit positions
	localparam int CGSF_GIT_SUM  = 7;
	localparam int CGSF_GIT_TIM  = 5;
	localparam int CGSF_GIT_BUF  = 4;
	localparam int CGSF_GIT_SERR = 3;
	localparam int CGSF_GIT_CERR = 2;
	localparam int CGSF_GIT_FERR = 1;
	localparam int CGSF_GIT_AERR = 0;
	localparam int CGSF_NFLAGS   = 6;

	// Bus levels, timer wrap, stuffing, CRC, start-up delay
	localparam logic           CGSF_RECESSIVE = 1'b1;
	localparam logic           CGSF_DOMINANT  = 1'b0;
	localparam logic [15:0]    CGSF_TIMER_MAX = 16'hFFFF;
	localparam logic [15:0]    CGSF_TIMER_ZERO = 16'h0000;
	localparam logic [2:0]     CGSF_STUFF_MAX = 3'h5;
	localparam logic [2:0]     CGSF_RUN_ONE   = 3'h1;
	localparam int             CGSF_CRC_W     = 15;
	localparam logic [14:0]    CGSF_CRC_POLY  = 15'h4599;
	localparam logic [14:0]    CGSF_CRC_INIT  = 15'h0000;
	localparam int             CGSF_CLK_HZ    = 10_000_000;
	localparam int             CGSF_START_CLK_PERIODS = 2;
	localparam logic [1:0]     CGSF_START_LAST =
		2'(CGSF_START_CLK_PERIODS - 1);

	// Controller run state
	typedef enum logic [1:0]
	{
		CGSF_STANDBY  = 2'b00,
		CGSF_STARTING = 2'b01,
		CGSF_RUNNING  = 2'b10,
		CGSF_STOPPING = 2'b11
	} cgsf_ctl_e;

	// Activity levels from the protocol engine
	typedef struct packed
	{
		logic ovl_tx;
		logic frame_tx;
		logic ack_tx;
		logic ifs;
		logic tx_pending;
		logic rx_busy;
		logic bus_off;
		logic err_passive;
	} cgsf_engine_s;

	// One sampled bus bit with its field context
	typedef struct packed
	{
		logic valid;
		logic level;
		logic sof;
		logic stuff_zone;
		logic crc_zone;
		logic crc_check;
		logic form_zone;
		logic ack_slot;
		logic is_tx;
	} cgsf_rxbit_s;
endpackage

// *** logic/cgsf_sticky.sv ***
`timescale 1ns/1ps
module cgsf_sticky
#(
	parameter int W = 6
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);
	// Set beats a clear in the same cycle so no event is lost
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= (q & ~clr) | set;
	end
endmodule

// *** logic/cgsf_crc15.sv ***
`timescale 1ns/1ps
module cgsf_crc15
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        init,
	input  wire logic        shift,
	input  wire logic        bit_in,
	output logic      [14:0] crc_q
);
	import cgsf_pkg::*;

	logic        fb;
	logic [14:0] crc_base;

	// Init folds into the first shifted bit
	always_comb
	begin
		crc_base = init ? CGSF_CRC_INIT : crc_q;
		fb       = bit_in ^ crc_base[CGSF_CRC_W-1];
	end

	// Feeding the received CRC field too leaves zero on a match
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			crc_q <= CGSF_CRC_INIT;
		else if (shift)
			crc_q <= {crc_base[13:0], 1'b0} ^ (fb ? CGSF_CRC_POLY : '0);
		else if (init)
			crc_q <= CGSF_CRC_INIT;
	end
endmodule

// *** verif/cgsf_cpu.sv ***
`timescale 1ns/1ps
module cgsf_cpu
(
	input  wire logic       ref_clk,
	output logic      [7:0] sfr_addr,
	output logic            sfr_wr,
	output logic            sfr_rd,
	output logic      [7:0] sfr_wdata,
	input  wire logic [7:0] sfr_rdata
);
	import cgsf_pkg::*;
	// Idle bus at time zero
	initial
	begin
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end
	// One-cycle strobe; released lines show the inverse, not stale data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = (a == CGSF_GSTA_ADDR) ? (d & 8'h5F) : d;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~sfr_wdata;
	endtask
	// Data is registered at the taking edge, picked up before release
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge ref_clk);
		d = sfr_rdata;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
	endtask
endmodule

// *** verif/cgsf_chk.sv ***
`timescale 1ns/1ps
module cgsf_chk
(
	input wire logic                   ref_clk,
	input wire logic                   rst_b,
	input wire logic [7:0]             sfr_addr,
	input wire logic                   sfr_wr,
	input wire logic                   sfr_rd,
	input wire logic [7:0]             sfr_wdata,
	input wire logic [7:0]             sfr_rdata,
	input wire logic                   enable_standby_control,
	input wire cgsf_pkg::cgsf_engine_s engine,
	input wire cgsf_pkg::cgsf_rxbit_s  rx_bit,
	input wire logic [15:0]            can_timer,
	input wire logic                   rx_buffer_full,
	input wire logic                   timer_irq_enable,
	input wire logic                   gen_err_irq_enable,
	input wire logic                   buf_irq_enable,
	input wire logic                   other_irq_req,
	input wire logic                   can_tx,
	input wire logic                   rx_enable,
	input wire logic                   machine_run,
	input wire logic                   can_irq,
	input wire logic [7:0]             general_status,
	input wire logic [7:0]             general_interrupt_flags
);
	import cgsf_pkg::*;
	logic [2:0] live_q;
	logic [7:0] gif;
	logic       form_set;
	// Mirrors the reset synchroniser plus one settle edge
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			live_q <= 3'h0;
		else
			live_q <= {live_q[1:0], 1'b1};
	end
	assign gif = general_interrupt_flags;
	assign form_set = rx_bit.valid & rx_bit.form_zone & ~rx_bit.level;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b || !live_q[2]);
	sequence s_cmd;
		$rose(enable_standby_control) && !machine_run && !general_status[2];
	endsequence
	sequence s_held;
		s_cmd ##1 enable_standby_control[*3];
	endsequence
	AST_START: assert property (s_held |=> machine_run && general_status[2])
		else $error("start delay wrong");
	AST_EARLY: assert property (s_cmd |=> !general_status[2] [*3])
		else $error("enabled flag early");
	AST_STBY: assert property (!machine_run |-> can_tx && !rx_enable)
		else $error("standby outputs wrong");
	AST_OVL: assert property (general_status[6] |-> $past(engine.ovl_tx))
		else $error("overload flag without cause");
	AST_TX: assert property (general_status[4] |-> $past(engine.frame_tx |
		engine.ack_tx | engine.ovl_tx | (engine.ifs & engine.tx_pending)))
		else $error("tx flag without cause");
	AST_RX: assert property (general_status[3] |-> $past(engine.rx_busy))
		else $error("rx flag without cause");
	AST_PASS: assert property (general_status[1:0] ==
		$past({engine.bus_off, engine.err_passive}))
		else $error("error state bits wrong");
	AST_RD: assert property (sfr_rd && sfr_addr == CGSF_GSTA_ADDR |=>
		sfr_rdata == $past(general_status))
		else $error("status read wrong");
	AST_SUM: assert property (gif[7] == can_irq)
		else $error("summary differs from irq");
	AST_IRQ: assert property (can_irq == $past((gif[5] & timer_irq_enable) |
		(gif[4] & buf_irq_enable) | ((|gif[3:0]) & gen_err_irq_enable) |
		other_irq_req)) else $error("irq not OR of requests");
	AST_TIM: assert property (can_timer == CGSF_TIMER_ZERO &&
		$past(can_timer) == CGSF_TIMER_MAX |=> gif[5])
		else $error("timer wrap flag missing");
	AST_BUF: assert property ($rose(rx_buffer_full) |=> gif[4])
		else $error("overrun flag missing");
	AST_FORM: assert property (machine_run && form_set |=> gif[1])
		else $error("form flag missing");
	AST_CLR: assert property (sfr_wr && sfr_addr == CGSF_GIT_ADDR &&
		!sfr_wdata[1] && !form_set |=> !gif[1])
		else $error("form flag not cleared");
endmodule
bind cgsf_top cgsf_chk cgsf_chk_i (.*);

// *** verif/tb_cgsf_top.sv ***
`timescale 1ns/1ps
module tb_cgsf_top;
	import cgsf_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst_b = 1'b0;
	logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata, rd;
	logic         sfr_wr, sfr_rd, can_tx, rx_enable, machine_run, can_irq;
	logic         enable_standby_control, engine_tx_level, rx_buffer_full;
	logic         timer_irq_enable, gen_err_irq_enable, buf_irq_enable;
	logic         other_irq_req;
	logic [7:0]   general_status, general_interrupt_flags;
	logic [15:0]  can_timer;
	cgsf_engine_s engine;
	cgsf_rxbit_s  rx_bit;
	int           n_errors = 0;
	int           tests_run = 0;
	int           k;
	cgsf_top cgsf_top_i (.*);
	cgsf_cpu cgsf_cpu_i (.*);
	always #50 ref_clk = ~ref_clk;
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic complete_run();
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Bounded wait on the run flag; overrun counts as a mismatch
	task automatic wait_run(input logic v);
		k = 0;
		while (machine_run !== v && k < 10)
		begin
			cyc(1);
			k++;
		end
		// A run flag that never settles ends the run as a failure
		if (machine_run !== v)
		begin
			chk(8'(v), 8'(machine_run));
			complete_run();
		end
	endtask
	// Status image while running, one cycle after the engine levels
	function automatic logic [7:0] exp_sta(input cgsf_engine_s e);
		return {1'b0, e.ovl_tx, 1'b0, e.frame_tx | e.ack_tx | e.ovl_tx |
			(e.ifs & e.tx_pending), e.rx_busy, 1'b1, e.bus_off,
			e.err_passive};
	endfunction
	// Bits a for n cycles then b once; flag check, then clear by zero
	task automatic err_case(input logic [8:0] a, input logic [8:0] b,
		input int n, input logic [7:0] e);
		rx_bit = cgsf_rxbit_s'(a);
		cyc(n);
		rx_bit = cgsf_rxbit_s'(b);
		cyc(1);
		rx_bit = '0;
		chk(e, general_interrupt_flags & 8'h3F);
		cgsf_cpu_i.wr(CGSF_GIT_ADDR, 8'h3F & ~e);
		cyc(2);
		chk(8'h00, general_interrupt_flags);
	endtask
	initial
	begin
		{enable_standby_control, rx_buffer_full, other_irq_req} = 3'h0;
		{timer_irq_enable, gen_err_irq_enable, buf_irq_enable} = 3'h0;
		engine_tx_level = 1'b1;
		engine = '0;
		rx_bit = '0;
		can_timer = 16'h1234;
		void'($urandom(32'h4A17));
		cyc(2);
		rst_b = 1'b1;
		cyc(3);
		cgsf_cpu_i.rd(CGSF_GIT_ADDR, rd);
		chk(CGSF_GIT_RST, rd);
		cgsf_cpu_i.wr(CGSF_GSTA_ADDR, 8'h5F);
		cgsf_cpu_i.rd(CGSF_GSTA_ADDR, rd);
		chk(CGSF_GSTA_RST, rd);
		cgsf_cpu_i.rd(8'h30, rd);
		chk(CGSF_RDATA_NONE, rd);
		enable_standby_control = 1'b1;
		wait_run(1'b1);
		chk(8'h04, 8'(k));
		cgsf_cpu_i.rd(CGSF_GSTA_ADDR, rd);
		chk(8'h04, rd);
		{timer_irq_enable, gen_err_irq_enable, buf_irq_enable} = 3'h7;
		for (int i = 0; i < 200; i++)
		begin
			engine = cgsf_engine_s'($urandom);
			engine_tx_level = 1'($urandom);
			cyc(1);
			chk(exp_sta(engine), general_status);
			chk(8'h00, 8'(can_irq));
			chk(8'({engine_tx_level, 1'b1}), 8'({can_tx, rx_enable}));
		end
		engine = '0;
		can_timer = CGSF_TIMER_MAX;
		cyc(1);
		can_timer = CGSF_TIMER_ZERO;
		cyc(1);
		chk(8'h20, general_interrupt_flags);
		cyc(1);
		chk(8'hA0, general_interrupt_flags);
		cgsf_cpu_i.wr(CGSF_GIT_ADDR, 8'h1F);
		cyc(1);
		chk(8'h00, general_interrupt_flags);
		rx_buffer_full = 1'b1;
		cyc(2);
		chk(8'h90, general_interrupt_flags);
		cgsf_cpu_i.wr(CGSF_GIT_ADDR, 8'h3F);
		chk(8'h90, general_interrupt_flags);
		cgsf_cpu_i.wr(CGSF_GIT_ADDR, 8'h2F);
		cyc(1);
		chk(8'h00, general_interrupt_flags);
		rx_buffer_full = 1'b0;
		err_case(9'h1A0, 9'h000, 5, 8'h00);
		err_case(9'h120, 9'h000, 6, 8'h08);
		err_case(9'h1D0, 9'h008, 1, 8'h04);
		err_case(9'h104, 9'h000, 1, 8'h02);
		err_case(9'h183, 9'h000, 1, 8'h01);
		other_irq_req = 1'b1;
		cyc(2);
		chk(8'h80, general_interrupt_flags);
		other_irq_req = 1'b0;
		// Disable mid-frame: the machine keeps running until it ends
		engine.frame_tx = 1'b1;
		engine_tx_level = 1'b0;
		enable_standby_control = 1'b0;
		cyc(4);
		chk(8'h14, general_status);
		engine.frame_tx = 1'b0;
		wait_run(1'b0);
		cyc(1);
		chk(8'h02, {6'h00, can_tx, rx_enable});
		chk(8'h00, general_status);
		complete_run();
	end
endmodule
